// [inc/serial_ch0_pkg.sv]
// constants shared by the serial channel 0 design
package serial_ch0_pkg;
    // ************************************
    // register byte offsets
    // ************************************
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_SHIFT = 8'h08;
    localparam logic [7:0] OFF_SLAVE_ADDR = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_CLK_LATCH = 8'h14;
    // ************************************
    // mode register fields
    // ************************************
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_LSB_FIRST = 2;
    localparam int MODE_INT_CLK = 3;
    localparam int MODE_ENABLE = 4;
    localparam int MODE_WAKEUP = 5;
    localparam int MODE_CLK_PORT_IN = 6;
    localparam logic [6:0] MODE_RESET = 7'h00;
    // ************************************
    // control register fields
    // ************************************
    localparam int CTRL_BUS_FREE_TRIG = 0;
    localparam int CTRL_CMD_TRIG = 1;
    localparam int CTRL_ACK_TRIG = 2;
    localparam int CTRL_AUTO_ACK = 3;
    localparam int CTRL_BUSY_AUTO = 4;
    localparam int CTRL_BUS_FREE_DET = 5;
    localparam int CTRL_CMD_DET = 6;
    localparam int CTRL_ACK_DET = 7;
    // ************************************
    // status register fields
    // ************************************
    localparam int STAT_DONE = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_PENDING = 2;
    localparam logic CLK_LATCH_RESET = 1'b1;
    // ************************************
    // modes and timing
    // ************************************
    typedef enum logic [1:0] {
        MODE_STOP, MODE_THREE_WIRE, MODE_TWO_WIRE, MODE_BUS
    } serial_mode_type;
    localparam int BYTE_BITS = 8;
    localparam int BUS_CLOCKS = 9;
    localparam int SYS_CLK_MHZ = 100;
    localparam int SCK_INT_PERIOD_NS = 1000;
    localparam int SCK_HALF_CYCLES = (SCK_INT_PERIOD_NS * SYS_CLK_MHZ) / 2000;
endpackage : serial_ch0_pkg

// [hdl/level_sync.sv]
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            meta_reg <= INIT;
            o_sync <= INIT;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : level_sync
`default_nettype wire

// [hdl/serial_ch0.sv]
// serial channel 0: 3-wire, 2-wire and bus modes behind an ahb-lite slave
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module serial_ch0 (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_serial_clock_ch0,
    output logic o_serial_clock_ch0,
    output logic o_serial_clock_ch0_oe_n,
    input wire logic i_serial_in_ch0,
    input wire logic i_bus_data_pin_a,
    output logic o_serial_out_ch0,
    output logic o_serial_out_ch0_oe_n,
    output logic o_transfer_done_irq_flag
);
    import serial_ch0_pkg::*;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            r[k] = v[7-k];
        end
        return r;
    endfunction : rev8

    // ************************************
    // pin synchronisers
    // ************************************
    logic [2:0] pins_sync;
    level_sync #(.WIDTH(3), .INIT(3'h7)) level_sync_inst (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_async({i_serial_clock_ch0, i_serial_in_ch0, i_bus_data_pin_a}),
        .o_sync(pins_sync)
    );
    logic sck_ext, si_s, line_s;
    assign sck_ext = pins_sync[2];
    assign si_s = pins_sync[1];
    assign line_s = pins_sync[0];

    // ************************************
    // bus slave
    // ************************************
    logic [6:0] mode_reg;
    logic [4:0] ctrl_reg;
    logic [7:0] shift_reg_ch0;
    logic [7:0] own_slave_address;
    logic clock_pin_output_latch;
    logic bus_free_detect, command_detect, acknowledge_detect;
    logic active_reg, pending_reg;
    logic [3:0] bit_cnt_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic addr_ok;
    serial_mode_type mode;
    logic shift_wr, done_set, lsb_first, int_clk, enable;

    assign mode = serial_mode_type'(mode_reg[MODE_SEL_LSB +: 2]);
    assign lsb_first = mode_reg[MODE_LSB_FIRST];
    assign int_clk = mode_reg[MODE_INT_CLK];
    assign enable = mode_reg[MODE_ENABLE];
    assign addr_ok = i_hsel && i_hready && i_htrans[1];
    assign shift_wr = wr_pend_reg && wr_addr_reg == OFF_SHIFT;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b0;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            wr_pend_reg <= addr_ok && i_hwrite;
            wr_addr_reg <= i_haddr;
            o_hrdata <= 32'h0000_0000;
            if (addr_ok && !i_hwrite) begin
                case (i_haddr)
                    OFF_MODE: o_hrdata <= {25'h0, mode_reg};
                    OFF_CTRL: o_hrdata <= {24'h0, acknowledge_detect, command_detect,
                        bus_free_detect, ctrl_reg[4:3], 3'h0};
                    OFF_SHIFT: o_hrdata <= {24'h0,
                        lsb_first ? rev8(shift_reg_ch0) : shift_reg_ch0};
                    OFF_STATUS: o_hrdata <= {29'h0, pending_reg, active_reg,
                        o_transfer_done_irq_flag};
                    OFF_CLK_LATCH: o_hrdata <= {31'h0, clock_pin_output_latch};
                    default: o_hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            mode_reg <= MODE_RESET;
            ctrl_reg <= 5'h00;
            own_slave_address <= 8'h00;
            clock_pin_output_latch <= CLK_LATCH_RESET;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                OFF_MODE: mode_reg <= i_hwdata[6:0];
                OFF_CTRL: ctrl_reg <= {i_hwdata[4:3], 3'h0};
                OFF_SLAVE_ADDR: own_slave_address <= i_hwdata[7:0];
                OFF_CLK_LATCH: clock_pin_output_latch <= i_hwdata[0];
                default: ;
            endcase
        end
    end

    // ************************************
    // serial clock source and edges
    // ************************************
    logic sck_int_reg, sck_prev_reg, sck_eff, sck_rise, sck_fall;
    logic [7:0] div_reg;
    // port latch gates the internal clock
    assign sck_eff = int_clk ? (sck_int_reg & clock_pin_output_latch) : sck_ext;
    assign sck_rise = sck_eff && !sck_prev_reg;
    assign sck_fall = !sck_eff && sck_prev_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            sck_int_reg <= 1'b1;
            div_reg <= 8'h00;
            sck_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_eff;
            if (!active_reg) begin
                sck_int_reg <= 1'b1;
                div_reg <= 8'h00;
            end else if (div_reg == 8'(SCK_HALF_CYCLES - 1)) begin
                sck_int_reg <= !sck_int_reg;
                div_reg <= 8'h00;
            end else begin
                div_reg <= div_reg + 8'h01;
            end
        end
    end

    // ************************************
    // transfer sequencing
    // ************************************
    logic bus_like, last_rise, ack_drive_reg, busy_drive_reg, so_latch_reg, line_prev_reg;
    logic addr_match;
    assign bus_like = mode == MODE_BUS;
    // eight data clocks, ninth for ack in bus mode
    assign last_rise = sck_rise && active_reg &&
        bit_cnt_reg == (bus_like ? 4'(BUS_CLOCKS - 1) : 4'(BYTE_BITS - 1));
    assign addr_match = bus_free_detect && shift_reg_ch0 == own_slave_address;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            active_reg <= 1'b0;
            pending_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
        end else if (mode == MODE_STOP) begin
            active_reg <= 1'b0;
            pending_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
        end else if (shift_wr && !active_reg) begin
            // no framing needed, enable set first
            pending_reg <= enable;
            bit_cnt_reg <= 4'h0;
        end else if (pending_reg && (!(mode != MODE_THREE_WIRE) || line_s)) begin
            pending_reg <= 1'b0;
            active_reg <= 1'b1;
        end else if (last_rise) begin
            active_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
        end else if (sck_rise && active_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            shift_reg_ch0 <= 8'h00;
        end else if (shift_wr && !active_reg) begin
            shift_reg_ch0 <= lsb_first ? rev8(i_hwdata[7:0]) : i_hwdata[7:0];
        end else if (active_reg && sck_rise && bit_cnt_reg < 4'(BYTE_BITS)) begin
            shift_reg_ch0 <= {shift_reg_ch0[6:0], mode == MODE_THREE_WIRE ? si_s : line_s};
        end
    end

    // output latch, triggers only while idle
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            so_latch_reg <= 1'b1;
        end else if (active_reg) begin
            if (sck_fall) begin
                so_latch_reg <= bit_cnt_reg < 4'(BYTE_BITS) ? shift_reg_ch0[7] : 1'b1;
            end
        end else if (wr_pend_reg && wr_addr_reg == OFF_CTRL) begin
            if (i_hwdata[CTRL_BUS_FREE_TRIG]) begin
                so_latch_reg <= 1'b1;
            end else if (i_hwdata[CTRL_CMD_TRIG]) begin
                so_latch_reg <= 1'b0;
            end
        end
    end

    // ack and busy pull the line low
    logic ack_req_reg;
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ack_req_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            busy_drive_reg <= 1'b0;
        end else begin
            if (wr_pend_reg && wr_addr_reg == OFF_CTRL && i_hwdata[CTRL_ACK_TRIG]) begin
                ack_req_reg <= 1'b1;
            end else if (ack_drive_reg) begin
                ack_req_reg <= 1'b0;
            end
            if (bus_like && active_reg && sck_fall && bit_cnt_reg == 4'(BYTE_BITS)) begin
                ack_drive_reg <= ctrl_reg[CTRL_AUTO_ACK] || ack_req_reg;
            end else if (shift_wr || (sck_fall && !active_reg)) begin
                ack_drive_reg <= 1'b0;
            end
            if (!ctrl_reg[CTRL_BUSY_AUTO] || shift_wr) begin
                busy_drive_reg <= 1'b0;
            end else if (last_rise && bus_like) begin
                busy_drive_reg <= 1'b1;
            end
        end
    end

    // ************************************
    // line signal detection and flags
    // ************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            line_prev_reg <= 1'b1;
            bus_free_detect <= 1'b0;
            command_detect <= 1'b0;
            acknowledge_detect <= 1'b0;
        end else begin
            line_prev_reg <= line_s;
            if (bus_like && sck_eff && !active_reg && line_s && !line_prev_reg) begin
                bus_free_detect <= 1'b1;
                command_detect <= 1'b0;
            end else if (bus_like && sck_eff && !active_reg && !line_s && line_prev_reg) begin
                command_detect <= 1'b1;
            end
            if (last_rise && bus_like && !line_s) begin
                acknowledge_detect <= 1'b1;
            end else if (shift_wr) begin
                acknowledge_detect <= 1'b0;
            end
        end
    end

    // done flag, set wins over clear
    assign done_set = last_rise && (!bus_like || !mode_reg[MODE_WAKEUP] || addr_match);
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_transfer_done_irq_flag <= 1'b0;
        end else if (done_set) begin
            o_transfer_done_irq_flag <= 1'b1;
        end else if (wr_pend_reg && wr_addr_reg == OFF_STATUS && i_hwdata[STAT_DONE]) begin
            o_transfer_done_irq_flag <= 1'b0;
        end
    end

    // ************************************
    // pin drivers
    // ************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_serial_clock_ch0 <= 1'b1;
            o_serial_clock_ch0_oe_n <= 1'b1;
            o_serial_out_ch0 <= 1'b1;
            o_serial_out_ch0_oe_n <= 1'b1;
        end else begin
            o_serial_clock_ch0 <= sck_int_reg & clock_pin_output_latch;
            // stop mode clock pin may be an input port
            o_serial_clock_ch0_oe_n <= !int_clk ||
                (mode == MODE_STOP && mode_reg[MODE_CLK_PORT_IN]);
            if (mode == MODE_STOP) begin
                o_serial_out_ch0 <= 1'b1;
                o_serial_out_ch0_oe_n <= 1'b1;
            end else if (mode == MODE_THREE_WIRE) begin
                o_serial_out_ch0 <= so_latch_reg;
                o_serial_out_ch0_oe_n <= 1'b0;
            end else begin
                o_serial_out_ch0 <= 1'b0;
                o_serial_out_ch0_oe_n <= so_latch_reg && !ack_drive_reg && !busy_drive_reg;
            end
        end
    end

    // ************************************
    // checks
    // ************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    chk_stop_idle: assert property (mode == MODE_STOP |=> !active_reg && !pending_reg)
        else $error("transfer runs in stop mode");
    chk_stop_pins: assert property (mode == MODE_STOP |=> o_serial_out_ch0_oe_n)
        else $error("data pin driven in stop mode");
    chk_busy_wait: assert property (pending_reg && !line_s && mode == MODE_BUS
        && $stable(mode_reg) |=> !active_reg)
        else $error("transfer began while busy");
    chk_late_enable: assert property (shift_wr && !active_reg && !enable
        |=> !pending_reg && !active_reg)
        else $error("write without enable started");
    chk_three_done: assert property (last_rise && mode == MODE_THREE_WIRE
        |=> o_transfer_done_irq_flag && !active_reg)
        else $error("flag missing after byte");
    chk_no_wakeup: assert property (last_rise && bus_like && !mode_reg[MODE_WAKEUP]
        |=> o_transfer_done_irq_flag)
        else $error("flag missing at ninth clock");
    chk_wakeup_miss: assert property (last_rise && bus_like && mode_reg[MODE_WAKEUP]
        && !addr_match && !o_transfer_done_irq_flag |=> !o_transfer_done_irq_flag)
        else $error("flag set without address match");
    chk_latch_hold: assert property (active_reg && $past(active_reg) && !$past(sck_fall)
        |-> $stable(so_latch_reg))
        else $error("output latch moved mid transfer");
    chk_bit_step: assert property (active_reg && sck_rise && !last_rise && mode != MODE_STOP
        |=> bit_cnt_reg == $past(bit_cnt_reg) + 4'h1)
        else $error("bit count did not advance");

    cov_three_wire: cover property (last_rise && mode == MODE_THREE_WIRE);
    cov_bus_match: cover property (last_rise && bus_like && mode_reg[MODE_WAKEUP] && addr_match);
    cov_busy_wait: cover property ((pending_reg && !line_s) [*3]);
endmodule : serial_ch0
`default_nettype wire

// [bench/serial_peer.sv]
// far-side serial peer: shifts bytes against the channel and can clock it
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input wire logic i_sck,
    input wire logic i_so,
    input wire logic i_load,
    input wire logic [7:0] i_tx,
    input wire logic i_ext_go,
    output logic o_sck_ext,
    output logic o_si,
    output logic [7:0] o_rx,
    output int o_rises
);
    logic [7:0] sr;
    initial begin
        o_sck_ext = 1'b1;
        o_si = 1'b0;
        o_rx = 8'h00;
        o_rises = 0;
        sr = 8'h00;
    end
    always @(posedge i_load) begin
        sr = i_tx;
    end
    // next bit put out on falling clock
    // peer sends data bytes with no framing signal
    always @(negedge i_sck) begin
        o_si <= sr[7];
        // toggling fill so a stale bit never looks valid
        sr <= {sr[6:0], ~sr[0]};
    end
    always @(posedge i_sck) begin
        o_rx <= {o_rx[6:0], i_so};
        o_rises <= o_rises + 1;
    end
    // peer as clock master: eight clocks, line stands high between frames
    always @(posedge i_ext_go) begin
        #3;
        repeat (8) begin
            #62.5 o_sck_ext = 1'b0;
            #62.5 o_sck_ext = 1'b1;
        end
    end
endmodule : serial_peer
`default_nettype wire

// [bench/serial_ch0_tb.sv]
// testbench for serial channel 0: register bus, 3-wire and bus transfers
`timescale 1ns/1ps
`default_nettype none
module serial_ch0_tb;
    import serial_ch0_pkg::*;
    logic clk, rstn, hsel, hwrite, hreadyout, hresp, sck_o, sck_oe_n, so, so_oe_n, flag;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, lfsr;
    logic busy_low, ext_go, load, sck_ext, si;
    logic [7:0] ptx, prx;
    int prises, error_cnt, samples_checked, cyc, r0;
    // pull-up on data line: released means high; released clock line follows the peer's clock
    wire logic sck_line = sck_oe_n ? sck_ext : sck_o;
    wire logic data_line = ~busy_low & (so_oe_n | so);

    serial_ch0 serial_ch0_inst (
        .i_clk_sys(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_serial_clock_ch0(sck_line), .o_serial_clock_ch0(sck_o),
        .o_serial_clock_ch0_oe_n(sck_oe_n), .i_serial_in_ch0(si),
        .i_bus_data_pin_a(data_line), .o_serial_out_ch0(so), .o_serial_out_ch0_oe_n(so_oe_n),
        .o_transfer_done_irq_flag(flag));
    serial_peer serial_peer_inst (
        .i_sck(sck_line), .i_so(data_line), .i_load(load), .i_tx(ptx), .i_ext_go(ext_go),
        .o_sck_ext(sck_ext), .o_si(si), .o_rx(prx), .o_rises(prises));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ************************************
    // helpers
    // ************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
    endfunction : rev8
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // budget covers all transfers with margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            $display("[ERR] %0t run too long", $time);
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic wait_flag();
        for (int i = 0; i < 3000 && flag !== 1'b1; i++) @(posedge clk);
    endtask : wait_flag
    task automatic clear_flag();
        bus(1'b1, OFF_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk(flag, 1'b0);
    endtask : clear_flag
    task automatic xfer3(input logic [7:0] mode, input logic [7:0] d);
        int r;
        ptx <= lfsr[15:8];
        load <= 1'b1;
        bus(1'b1, OFF_MODE, {24'h0, mode});
        r = prises;
        // order chosen before data goes in
        bus(1'b1, OFF_SHIFT, {24'h0, d});
        load <= 1'b0;
        ext_go <= ~mode[3];
        wait_flag();
        ext_go <= 1'b0;
        chk(prises - r, 8);
        chk(flag, 1'b1);
        // line order reversed, peer stays msb first
        chk(prx, mode[2] ? rev8(d) : d);
        rdchk(OFF_SHIFT, {24'h0, mode[2] ? rev8(ptx) : ptx});
        clear_flag();
    endtask : xfer3
    // ************************************
    // main sequence
    // ************************************
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hsize = 3'h2;
        hwrite = 1'b0;
        hwdata = 32'h0;
        busy_low = 1'b0;
        ext_go = 1'b0;
        load = 1'b0;
        ptx = 8'h00;
        lfsr = 32'h000116B8;
        rstn = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk(OFF_MODE, 32'h0);
        rdchk(OFF_CLK_LATCH, 32'h1);
        rdchk(8'h20, 32'h0);
        chk(so_oe_n, 1'b1);
        bus(1'b1, OFF_SHIFT, 32'h5A);
        rdchk(OFF_SHIFT, 32'h5A);
        rdchk(OFF_STATUS, 32'h0);
        chk(hresp, 1'b0);
        bus(1'b1, OFF_MODE, 32'h48);
        repeat (2) @(posedge clk);
        chk(sck_oe_n, 1'b1);
        $display("test stop done");
        bus(1'b1, OFF_MODE, 32'h09);
        bus(1'b1, OFF_SHIFT, 32'h3C);
        bus(1'b1, OFF_MODE, 32'h19);
        repeat (300) @(posedge clk);
        rdchk(OFF_STATUS, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        chk(so, 1'b0);
        bus(1'b1, OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk(so, 1'b1);
        bus(1'b1, OFF_CLK_LATCH, 32'h0);
        repeat (2) @(posedge clk);
        chk(sck_o, 1'b0);
        bus(1'b1, OFF_CLK_LATCH, 32'h1);
        $display("test idle done");
        // corners first, then random bytes, both orders
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            xfer3(i[0] ? 8'h1D : 8'h19, i < 2 ? {8{i[0]}} : lfsr[7:0]);
        end
        // peer clocks the link: external clock selected
        xfer3(8'h11, 8'hA5);
        $display("test three_wire done");
        busy_low <= 1'b1;
        bus(1'b1, OFF_MODE, 32'h1B);
        r0 = prises;
        bus(1'b1, OFF_SHIFT, 32'hFF);
        repeat (500) @(posedge clk);
        chk(prises - r0, 0);
        busy_low <= 1'b0;
        wait_flag();
        chk(prises - r0, 9);
        chk(flag, 1'b1);
        clear_flag();
        $display("test bus done");
        // wakeup addressing, device clocks and hears its own line
        bus(1'b1, OFF_MODE, 32'h3B);
        bus(1'b1, OFF_SLAVE_ADDR, 32'h5C);
        // bus free: line rises, clock high
        busy_low <= 1'b1;
        repeat (4) @(posedge clk);
        busy_low <= 1'b0;
        repeat (4) @(posedge clk);
        rdchk(OFF_CTRL, 32'h20);
        busy_low <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk(OFF_CTRL, 32'h60);
        // line released while clock held low
        bus(1'b1, OFF_CLK_LATCH, 32'h0);
        busy_low <= 1'b0;
        repeat (4) @(posedge clk);
        bus(1'b1, OFF_CLK_LATCH, 32'h1);
        bus(1'b1, OFF_SHIFT, 32'h5C);
        wait_flag();
        chk(flag, 1'b1);
        clear_flag();
        // command signal only before next byte
        busy_low <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b1, OFF_CLK_LATCH, 32'h0);
        busy_low <= 1'b0;
        repeat (4) @(posedge clk);
        bus(1'b1, OFF_CLK_LATCH, 32'h1);
        // ack trigger set while idle, held until ack is driven
        bus(1'b1, OFF_CTRL, 32'h4);
        bus(1'b1, OFF_SHIFT, 32'hA3);
        wait_flag();
        chk(flag, 1'b0);
        rdchk(OFF_CTRL, 32'hE0);
        rdchk(OFF_STATUS, 32'h0);
        $display("test wakeup done");
        summarize();
    end
endmodule : serial_ch0_tb
`default_nettype wire
